// ### hdl/spd_consts.svh
// constants of the register-space page decoder
// assumes an 8-bit core issuing one access at a time
// Notes on behaviour
// - page select at 0xbf, all pages, resets zero
// - accesses steered by the current page
// - writing page select changes later accesses
// - reading page select returns whole page byte
// - bit operations only at low nibble 0/8
// - common registers decode alike on both pages
// - paged addresses pick page 0 or F register
// - only direct accesses 0x80 to 0xff answered
// - only pages 0x0 and 0xf implemented
`ifndef SPD_CONSTS_SVH
`define SPD_CONSTS_SVH

`define SPD_PAGE_ADDR 8'hbf
`define SPD_PAGE_RST 8'h00
`define SPD_PAGE_0 8'h00
`define SPD_PAGE_F 8'h0f
`define SPD_SPACE_LO 8'h80
`define SPD_BIT_NIB_A 3'h0
`define SPD_BIT_NIB_B 3'h0
`define SPD_NIB_MASK 8'h07
`define SPD_ZERO_BYTE 8'h00

`endif

// ### hdl/spd_pkg.sv
// types shared by the page decoder files
// assumes spd_consts.svh is on the include path
`default_nettype none
package spd_pkg;
   typedef enum logic [1:0] {
      SPD_BANK_NONE = 2'b00,
      SPD_BANK_COMMON = 2'b01,
      SPD_BANK_P0 = 2'b10,
      SPD_BANK_PF = 2'b11
   } spd_bank_t;
   typedef enum logic [1:0] {
      SPD_BIT_SET = 2'b00,
      SPD_BIT_CLR = 2'b01,
      SPD_BIT_TEST = 2'b10
   } spd_bitop_t;
   typedef enum logic [1:0] {
      SPD_IDLE = 2'b00,
      SPD_RD_WAIT = 2'b01,
      SPD_BIT_WAIT = 2'b10
   } spd_state_t;
endpackage
`default_nettype wire

// ### hdl/spd_decode.sv
// address map decode of the upper register space
// assumes address already known to be in 0x80..0xff
`include "spd_consts.svh"
`default_nettype none
module spd_decode
   import spd_pkg::*;
(
   input wire logic [7:0] addr,
   input wire logic [7:0] page,
   output spd_bank_t bank,
   output logic bit_ok,
   output logic page_reg
);
   // ***************************************
   // map tables
   // ***************************************
   function automatic logic is_paged(input logic [7:0] a);
      is_paged = (a >= 8'h91 && a <= 8'h95) || a == 8'hb9 || (a >= 8'hc0 && a <= 8'hc2) ||
                 (a >= 8'hc8 && a <= 8'hcf && a != 8'hc9) || a == 8'he4;
   endfunction

   function automatic logic is_hole(input logic [7:0] a);
      is_hole = a == 8'h96 || a == 8'h97 || a == 8'hab || a == 8'had || a == 8'hd7;
   endfunction

   // ***************************************
   // bank choice
   // ***************************************
   always_comb begin
      bank = SPD_BANK_COMMON;
      if (is_hole(addr)) begin
         bank = SPD_BANK_NONE;
      end else if (is_paged(addr)) begin
         if (page == `SPD_PAGE_0) begin
            bank = SPD_BANK_P0;
         end else if (page == `SPD_PAGE_F) begin
            bank = SPD_BANK_PF;
         end else begin
            bank = SPD_BANK_NONE;
         end
      end
   end

   assign bit_ok = (addr & `SPD_NIB_MASK) == `SPD_ZERO_BYTE;
   assign page_reg = addr == `SPD_PAGE_ADDR;
endmodule
`default_nettype wire

// ### hdl/spd_top.sv
// page decoder between core and peripheral registers
// assumes one access per request pulse, peripheral read data combinational
`include "spd_consts.svh"
`default_nettype none
module spd_top
   import spd_pkg::*;
#(
   parameter int DW = 8
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic core_req,
   input wire logic core_direct,
   input wire logic [7:0] core_addr,
   input wire logic core_wr,
   input wire logic [DW-1:0] core_wdata,
   input wire logic core_bit,
   input wire logic [1:0] core_bit_op,
   input wire logic [2:0] core_bit_pos,
   output logic [DW-1:0] core_rdata_r,
   output logic core_done_r,
   output logic core_err_r,
   output logic core_busy_r,
   output logic [7:0] page_sel_r,
   output logic [7:0] periph_addr_r,
   output spd_bank_t periph_bank_r,
   output logic periph_rd_r,
   output logic periph_wr_r,
   output logic [DW-1:0] periph_wdata_r,
   input wire logic [DW-1:0] periph_rdata
);
   // ***************************************
   // decode
   // ***************************************
   spd_bank_t dec_bank;
   logic dec_bit_ok;
   logic dec_page_reg;
   logic take;

   spd_decode u_dec (
      .addr(core_addr),
      .page(page_sel_r),
      .bank(dec_bank),
      .bit_ok(dec_bit_ok),
      .page_reg(dec_page_reg)
   );

   spd_state_t state_r, state_nxt;
   logic [7:0] page_nxt;
   logic [DW-1:0] core_rdata_nxt, periph_wdata_nxt;
   logic core_done_nxt, core_err_nxt, core_busy_nxt;
   logic [7:0] periph_addr_nxt;
   spd_bank_t periph_bank_nxt;
   logic periph_rd_nxt, periph_wr_nxt;
   logic [1:0] bop_r, bop_nxt;
   logic [2:0] bpos_r, bpos_nxt;

   // idle only; a request while busy is dropped
   assign take = core_req && core_direct && core_addr >= `SPD_SPACE_LO && state_r == SPD_IDLE;

   // ***************************************
   // bit position mask
   // ***************************************
   logic [DW-1:0] pos_mask;

   // one compare per bit, so no shifter sits in the write-back path
   for (genvar g = 0; g < DW; g++) begin : g_mask
      assign pos_mask[g] = bpos_r == 3'(g);
   end

   // ***************************************
   // request class
   // ***************************************
   // one class per taken request; the order of the tests is the priority
   logic cls_refuse, cls_page, cls_none, cls_bit, cls_wr, cls_rd;

   always_comb begin
      cls_refuse = 1'b0;
      cls_page = 1'b0;
      cls_none = 1'b0;
      cls_bit = 1'b0;
      cls_wr = 1'b0;
      cls_rd = 1'b0;
      if (take) begin
         if (core_bit && !dec_bit_ok) begin
            cls_refuse = 1'b1;
         end else if (dec_page_reg) begin
            cls_page = 1'b1;
         end else if (dec_bank == SPD_BANK_NONE) begin
            cls_none = 1'b1;
         end else if (core_bit) begin
            cls_bit = 1'b1;
         end else if (core_wr) begin
            cls_wr = 1'b1;
         end else begin
            cls_rd = 1'b1;
         end
      end
   end

   // ***************************************
   // next state
   // ***************************************
   always_comb begin
      state_nxt = state_r;
      core_rdata_nxt = core_rdata_r;
      core_done_nxt = 1'b0;
      core_err_nxt = 1'b0;
      periph_addr_nxt = periph_addr_r;
      periph_bank_nxt = periph_bank_r;
      periph_rd_nxt = 1'b0;
      periph_wr_nxt = 1'b0;
      periph_wdata_nxt = periph_wdata_r;
      bop_nxt = bop_r;
      bpos_nxt = bpos_r;
      case (state_r)
         SPD_IDLE: begin
            if (take) begin
               periph_addr_nxt = core_addr;
               periph_bank_nxt = dec_bank;
               bop_nxt = core_bit_op;
               bpos_nxt = core_bit_pos;
            end
            if (cls_refuse) begin
               core_done_nxt = 1'b1;
               core_err_nxt = 1'b1;
               core_rdata_nxt = '0;
            end
            if (cls_page) begin
               core_done_nxt = 1'b1;
               if (!core_wr) begin
                  core_rdata_nxt = DW'(page_sel_r);
               end
            end
            if (cls_none) begin
               core_done_nxt = 1'b1;
               core_rdata_nxt = '0;
            end
            if (cls_bit) begin
               periph_rd_nxt = 1'b1;
               state_nxt = SPD_BIT_WAIT;
            end
            if (cls_wr) begin
               periph_wr_nxt = 1'b1;
               periph_wdata_nxt = core_wdata;
               core_done_nxt = 1'b1;
            end
            if (cls_rd) begin
               periph_rd_nxt = 1'b1;
               state_nxt = SPD_RD_WAIT;
            end
         end
         SPD_RD_WAIT: begin
            core_rdata_nxt = periph_rdata;
            core_done_nxt = 1'b1;
            state_nxt = SPD_IDLE;
         end
         SPD_BIT_WAIT: begin
            // read-modify-write keeps the other seven bits intact
            core_rdata_nxt = DW'(|(periph_rdata & pos_mask));
            core_done_nxt = 1'b1;
            state_nxt = SPD_IDLE;
            if (bop_r == SPD_BIT_SET) begin
               periph_wdata_nxt = periph_rdata | pos_mask;
               periph_wr_nxt = 1'b1;
            end else if (bop_r == SPD_BIT_CLR) begin
               periph_wdata_nxt = periph_rdata & ~pos_mask;
               periph_wr_nxt = 1'b1;
            end else if (bop_r != SPD_BIT_TEST) begin
               core_err_nxt = 1'b1;
            end
         end
         default: begin
            state_nxt = SPD_IDLE;
         end
      endcase
      core_busy_nxt = state_nxt != SPD_IDLE;
   end

   // ***************************************
   // page register
   // ***************************************
   // kept whole; only 0x00 and 0x0f reach paged registers
   always_comb begin
      page_nxt = page_sel_r;
      if (cls_page && core_wr) begin
         page_nxt = core_wdata[7:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         page_sel_r <= `SPD_PAGE_RST;
      end else begin
         page_sel_r <= page_nxt;
      end
   end

   // ***************************************
   // registers
   // ***************************************
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_r <= SPD_IDLE;
         core_rdata_r <= '0;
         core_done_r <= 1'b0;
         core_err_r <= 1'b0;
         core_busy_r <= 1'b0;
         periph_addr_r <= `SPD_ZERO_BYTE;
         periph_bank_r <= SPD_BANK_NONE;
         periph_rd_r <= 1'b0;
         periph_wr_r <= 1'b0;
         periph_wdata_r <= '0;
         bop_r <= 2'h0;
         bpos_r <= 3'h0;
      end else begin
         state_r <= state_nxt;
         core_rdata_r <= core_rdata_nxt;
         core_done_r <= core_done_nxt;
         core_err_r <= core_err_nxt;
         core_busy_r <= core_busy_nxt;
         periph_addr_r <= periph_addr_nxt;
         periph_bank_r <= periph_bank_nxt;
         periph_rd_r <= periph_rd_nxt;
         periph_wr_r <= periph_wr_nxt;
         periph_wdata_r <= periph_wdata_nxt;
         bop_r <= bop_nxt;
         bpos_r <= bpos_nxt;
      end
   end
endmodule
`default_nettype wire

// ### bench/spd_top_monitor.sv
// assertions on the page decoder's core and peripheral ports
// assumes one clock and a synchronous reset
`default_nettype none
module spd_top_monitor
   import spd_pkg::*;
#(parameter int DW = 8) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic core_req,
   input wire logic core_direct,
   input wire logic [7:0] core_addr,
   input wire logic core_wr,
   input wire logic [DW-1:0] core_wdata,
   input wire logic core_bit,
   input wire logic [DW-1:0] core_rdata_r,
   input wire logic core_done_r,
   input wire logic core_err_r,
   input wire logic core_busy_r,
   input wire logic [7:0] page_sel_r,
   input wire logic periph_rd_r,
   input wire logic periph_wr_r,
   input wire spd_bank_t periph_bank_r,
   input wire logic [DW-1:0] periph_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic tk, st;
   // done cycle left out: the bench never asks there
   assign tk = core_req && core_direct && core_addr[7] && !core_busy_r && !core_done_r;
   assign st = periph_rd_r || periph_wr_r;
   page_rst_a:
      assert property ($fell(rst) |-> page_sel_r == 8'h00) else $error("page not cleared");
   page_wr_a:
      assert property (tk && core_addr == 8'hbf && core_wr && !core_bit |=> page_sel_r == $past(core_wdata))
      else $error("page write lost");
   page_hold_a:
      assert property (!(core_req && core_addr == 8'hbf) |=> $stable(page_sel_r)) else $error("page moved");
   rd_data_a:
      assert property (tk && !core_wr && !core_bit ##1 periph_rd_r |=>
                       core_done_r && core_rdata_r == $past(periph_rdata))
      else $error("read data lost");
   bit_refuse_a:
      assert property (tk && core_bit && core_addr[2:0] != 3'h0 |=> core_err_r && core_rdata_r == 8'h00 && !st)
      else $error("bit op not refused");
   no_answer_a:
      assert property (core_req && !core_busy_r && !core_done_r && !(core_direct && core_addr[7]) |=> !core_done_r)
      else $error("answered outside space");
   err_done_a:
      assert property (core_err_r |-> core_done_r && !periph_wr_r) else $error("err without done");
   paged_bank_a:
      assert property (st && periph_bank_r[1] |-> page_sel_r == {4'h0, {4{periph_bank_r[0]}}})
      else $error("bad page bank");
   strobe_bank_a:
      assert property (st |-> periph_bank_r != SPD_BANK_NONE) else $error("reserved strobed");
   page_rd_a:
      assert property (tk && core_addr == 8'hbf && !core_wr && !core_bit |=>
                       core_done_r && core_rdata_r == $past(page_sel_r))
      else $error("page read wrong");
   busy_answer_a:
      assert property (core_busy_r |-> !core_done_r ##1 core_done_r) else $error("busy without answer");
   cover property (tk && core_addr == 8'hbf && core_wr);
   cover property (core_err_r);
   cover property (periph_rd_r && periph_bank_r == SPD_BANK_PF);
endmodule
`default_nettype wire

// ### bench/spd_periph_model.sv
// peripheral registers behind the decoder, one byte per bank and address
// assumes one-cycle strobes from the decoder
`default_nettype none
module spd_periph_model
   import spd_pkg::*;
(
   input wire logic mclk,
   input wire logic [7:0] periph_addr_r,
   input wire spd_bank_t periph_bank_r,
   input wire logic periph_rd_r,
   input wire logic periph_wr_r,
   input wire logic [7:0] periph_wdata_r,
   output logic [7:0] periph_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] m [1024];
   initial foreach (m[i]) m[i] = 8'h00;
   // off-strobe the bus shows junk, not the last byte
   assign periph_rdata = periph_rd_r ? m[{periph_bank_r, periph_addr_r}] : ~m[{periph_bank_r, periph_addr_r}];
   always @(posedge mclk) if (periph_wr_r) m[{periph_bank_r, periph_addr_r}] <= periph_wdata_r;
endmodule
`default_nettype wire

// ### bench/sfr_page_decoder_tb.sv
// random and corner traffic through spd_top against a shadow map
// assumes the peripheral model answers reads
`default_nettype none
module sfr_page_decoder_tb import spd_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 0, rst = 1, core_req = 0, core_direct = 0, core_wr = 0, core_bit = 0;
   logic core_done_r, core_err_r, core_busy_r, periph_rd_r, periph_wr_r;
   logic [7:0] core_addr = 8'h80, core_wdata = 8'h00, core_rdata_r, page_sel_r, periph_addr_r, periph_wdata_r;
   logic [7:0] periph_rdata, pg = 8'h00, a, d, s, sv;
   logic [1:0] core_bit_op = 2'h0;
   logic [2:0] core_bit_pos = 3'h0;
   logic [15:0] lf = 16'hef9a;
   logic [7:0] sh [1024];
   logic [7:0] cs [8] = '{8'h91, 8'h95, 8'hb9, 8'hc0, 8'hc8, 8'hc9, 8'he4, 8'h96};
   spd_bank_t periph_bank_r;
   int failures = 0, comparisons = 0;
   spd_top spd_top_i (.*);
   spd_periph_model spd_periph_model_i (.*);
   initial forever #25 mclk = ~mclk;
   initial begin
      #400000;
      failures++;
      test_done();
   end
   function automatic logic [7:0] rnd();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return lf[7:0];
   endfunction
   function automatic spd_bank_t eb(logic [7:0] ad, logic [7:0] p);
      if (ad inside {8'h96, 8'h97, 8'hab, 8'had, 8'hd7, 8'hbf}) return SPD_BANK_NONE;
      if (!(ad inside {[8'h91:8'h95], 8'hb9, [8'hc0:8'hc2], 8'hc8, [8'hca:8'hcf], 8'he4})) return SPD_BANK_COMMON;
      return p == 8'h00 ? SPD_BANK_P0 : p == 8'h0f ? SPD_BANK_PF : SPD_BANK_NONE;
   endfunction
   task automatic chk(string n, logic [7:0] g, logic [7:0] e);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic test_done();
      if (failures == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic acc(logic [7:0] ad, logic w, logic [7:0] dt, logic b, logic [1:0] op, logic [2:0] ps, logic dr);
      int n;
      logic rf;
      logic [9:0] ix;
      spd_bank_t e;
      e = eb(ad, pg);
      ix = {e, ad};
      rf = b && ad[2:0] != 3'h0;
      @(negedge mclk);
      {core_addr, core_wr, core_wdata, core_bit} = {ad, w, dt, b};
      {core_bit_op, core_bit_pos, core_direct, core_req} = {op, ps, dr, 1'b1};
      @(negedge mclk);
      core_req = 1'b0;
      n = 0;
      while (core_done_r !== 1'b1 && n < 3) begin
         @(negedge mclk);
         n++;
      end
      chk("done", {7'h0, core_done_r}, {7'h0, dr & ad[7]});
      if (core_done_r !== 1'b1) return;
      chk("err", {7'h0, core_err_r}, {7'h0, rf || (b && op == 2'h3 && e != SPD_BANK_NONE)});
      if (ad == 8'hbf && !b) begin
         if (w) pg = dt;
         else chk("page", core_rdata_r, pg);
      end else if (rf || e == SPD_BANK_NONE) begin
         if (!w || b) chk("rsv", core_rdata_r, 8'h00);
      end else begin
         chk("bank", {6'h0, periph_bank_r}, {6'h0, e});
         chk("addr", periph_addr_r, ad);
         if (b) begin
            chk("bit", core_rdata_r, {7'h0, sh[ix][ps]});
            if (op == 2'h0) sh[ix][ps] = 1'b1;
            if (op == 2'h1) sh[ix][ps] = 1'b0;
         end else if (w) sh[ix] = dt;
         else chk("data", core_rdata_r, sh[ix]);
      end
   endtask
   initial begin
      foreach (sh[i]) sh[i] = 8'h00;
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      acc(8'hbf, 0, 0, 0, 0, 0, 1);
      for (int i = 0; i < 600; i++) begin
         a = rnd() | 8'h80;
         d = rnd();
         s = rnd();
         case (s[7:5])
            3'h0: acc(8'hbf, 1, s[4] ? 8'h0f : s[3] ? 8'h00 : d, 0, 0, 0, 1);
            3'h1: acc(s[2] ? a : a & 8'hf8, s[3], d, 1, d[1:0], d[4:2], 1);
            3'h2: acc(a & {s[0], 7'h7f}, s[3], d, 0, 0, 0, s[1]);
            3'h3: acc(cs[d[2:0]], s[0], d, 0, 0, 0, 1);
            default: acc(a, s[0], d, 0, 0, 0, 1);
         endcase
      end
      rst = 1'b1;
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      pg = 8'h00;
      acc(8'hbf, 0, 0, 0, 0, 0, 1);
      // handler style: save the page, work on page f, put the page back
      sv = pg;
      acc(8'hbf, 1, 8'h0f, 0, 0, 0, 1);
      acc(8'hc8, 1, 8'h5a, 0, 0, 0, 1);
      acc(8'hc8, 0, 8'h00, 0, 0, 0, 1);
      acc(8'hbf, 1, sv, 0, 0, 0, 1);
      acc(8'hbf, 0, 8'h00, 0, 0, 0, 1);
      acc(8'hc8, 0, 8'h00, 0, 0, 0, 1);
      test_done();
   end
endmodule
bind spd_top spd_top_monitor #(.DW(DW)) spd_top_monitor_i (.*);
`default_nettype wire
